// *** hw/xcvr_pkg.sv ***
// Constants shared by the octal bus transceiver and register block.
// Assumes one 20 MHz clock and an AXI4-Lite master on the register side.

`default_nettype none

package xcvr_pkg;

	// Widths
	localparam int LINE_W = 8;
	localparam int PIN_W  = 22;
	localparam int ADDR_W = 8;

	// Bit positions in the synchronised pin vector
	localparam int P_A_LSB  = 0;
	localparam int P_B_LSB  = 8;
	localparam int P_BEN    = 16;
	localparam int P_AEN_N  = 17;
	localparam int P_ABSEL  = 18;
	localparam int P_BASEL  = 19;
	localparam int P_ABCLK  = 20;
	localparam int P_BACLK  = 21;

	// Synchroniser reset: A enable reads inactive (high)
	localparam logic [PIN_W-1:0] PIN_SYNC_RST = 22'h02_0000;

	// Register offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] AB_OFS   = 8'h04;
	localparam logic [ADDR_W-1:0] BA_OFS   = 8'h08;
	localparam logic [ADDR_W-1:0] PINS_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] LIVE_OFS = 8'h10;

	// Control fields
	localparam int CTRL_ISO_BIT    = 0;
	localparam int CTRL_CAP_AB_BIT = 1;
	localparam int CTRL_CAP_BA_BIT = 2;
	localparam logic CTRL_ISO_RST  = 1'h0;

	// Pin status fields
	localparam int PS_BEN    = 0;
	localparam int PS_AEN_N  = 1;
	localparam int PS_ABSEL  = 2;
	localparam int PS_BASEL  = 3;
	localparam int PS_ADRIVE = 4;
	localparam int PS_BDRIVE = 5;
	localparam int LIVE_B_LSB = 8;

	// Responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// Word-aligned address match
	function automatic logic regHit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs);
		regHit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

endpackage

`default_nettype wire

// *** hw/capture_if.sv ***
// Carrier between the top and one capture register.
// Assumes the user side produces a one-cycle load pulse on mclk.

`timescale 1ns/100ps
`default_nettype none

interface capture_if
	import xcvr_pkg::*;
	();

	logic              takeEdge;
	logic [LINE_W-1:0] source;
	logic [LINE_W-1:0] value;

	modport store (input takeEdge, input source, output value);
	modport user  (output takeEdge, output source, input value);

endinterface

`default_nettype wire

// *** hw/pin_sync.sv ***
// Two-flop synchroniser for every pin that enters the block.
// Assumes pins are asynchronous to mclk; reset is synchronous.

`timescale 1ns/100ps
`default_nettype none

module pin_sync
	import xcvr_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [PIN_W-1:0] pinsRaw,
	output logic      [PIN_W-1:0] pinsSync
);

	logic [PIN_W-1:0] stage1_q;
	logic [PIN_W-1:0] stage2_q;

	// First stage feeds only the second
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stage1_q <= PIN_SYNC_RST;
			stage2_q <= PIN_SYNC_RST;
		end
		else
		begin
			stage1_q <= pinsRaw;
			stage2_q <= stage1_q;
		end
	end

	assign pinsSync = stage2_q;

endmodule

`default_nettype wire

// *** hw/capture_reg.sv ***
// One 8-bit capture register of the transceiver.
// Assumes a one-cycle load pulse; contents have no reset.

`timescale 1ns/100ps
`default_nettype none

module capture_reg
	import xcvr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	capture_if.store  cap
);

	logic [LINE_W-1:0] stored_q;
	logic              loaded_q;

	// No reset: contents undefined until the first load
	always_ff @(posedge mclk)
	begin
		if (cap.takeEdge)
			stored_q <= cap.source;
	end

	assign cap.value = stored_q;

	// Marks the first load so the hold check skips unknown contents
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			loaded_q <= 1'b0;
		else if (cap.takeEdge)
			loaded_q <= 1'b1;
	end

	capture_load_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		cap.takeEdge |=> (cap.value == $past(cap.source)))
		else $error("capture register missed its load");

	capture_hold_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(loaded_q && !cap.takeEdge) |=> $stable(cap.value))
		else $error("capture register changed without a load");

endmodule

`default_nettype wire

// *** hw/octal_bus_transceiver_register.sv ***
// Octal two-way bus transceiver with one capture register per direction.
// Assumes pins are asynchronous to mclk and an AXI4-Lite master.

`timescale 1ns/100ps
`default_nettype none

module octal_bus_transceiver_register
	import xcvr_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Transceiver pins
	input  wire logic              bPortDriveEnable,
	input  wire logic              aPortDriveEnable_n,
	input  wire logic              aToBCaptureClock,
	input  wire logic              bToACaptureClock,
	input  wire logic              aToBSourceSelect,
	input  wire logic              bToASourceSelect,
	input  wire logic [LINE_W-1:0] portALinesIn,
	output logic      [LINE_W-1:0] portALinesOut,
	output logic                   portALinesOe,
	input  wire logic [LINE_W-1:0] portBLinesIn,
	output logic      [LINE_W-1:0] portBLinesOut,
	output logic                   portBLinesOe,
	// AXI4-Lite slave
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic      [1:0]        bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp
);

	// ==============================================================
	// Pin synchronisation
	// ==============================================================
	logic [PIN_W-1:0]  pinsRaw;
	logic [PIN_W-1:0]  pinsSync;
	logic [LINE_W-1:0] aSync;
	logic [LINE_W-1:0] bSync;
	logic              bEnS;
	logic              aEnS_n;
	logic              abSelS;
	logic              baSelS;
	logic              abClkS;
	logic              baClkS;

	assign pinsRaw = {bToACaptureClock, aToBCaptureClock,
		bToASourceSelect, aToBSourceSelect,
		aPortDriveEnable_n, bPortDriveEnable,
		portBLinesIn, portALinesIn};

	pin_sync pinSync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.pinsRaw  (pinsRaw),
		.pinsSync (pinsSync)
	);

	assign aSync  = pinsSync[P_A_LSB +: LINE_W];
	assign bSync  = pinsSync[P_B_LSB +: LINE_W];
	assign bEnS   = pinsSync[P_BEN];
	assign aEnS_n = pinsSync[P_AEN_N];
	assign abSelS = pinsSync[P_ABSEL];
	assign baSelS = pinsSync[P_BASEL];
	assign abClkS = pinsSync[P_ABCLK];
	assign baClkS = pinsSync[P_BACLK];

	// ==============================================================
	// Capture clock edges
	// ==============================================================
	logic abClkPrev_q;
	logic baClkPrev_q;
	logic swCapAb_q;
	logic swCapBa_q;
	logic abEdge;
	logic baEdge;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			abClkPrev_q <= 1'b0;
			baClkPrev_q <= 1'b0;
		end
		else
		begin
			abClkPrev_q <= abClkS;
			baClkPrev_q <= baClkS;
		end
	end

	// Edges load regardless of selects and enables
	assign abEdge = (abClkS & ~abClkPrev_q) | swCapAb_q;
	assign baEdge = (baClkS & ~baClkPrev_q) | swCapBa_q;

	// ==============================================================
	// Capture registers
	// ==============================================================
	capture_if abCap ();
	capture_if baCap ();

	logic [LINE_W-1:0] aOut_q;
	logic [LINE_W-1:0] bOut_q;
	logic              aOe_q;
	logic              bOe_q;

	// Source is what the port carries, our own drive included,
	// so one direction's data lands in both registers
	assign abCap.takeEdge = abEdge;
	assign abCap.source   = aOe_q ? aOut_q : aSync;
	assign baCap.takeEdge = baEdge;
	assign baCap.source   = bOe_q ? bOut_q : bSync;

	capture_reg abReg (
		.mclk  (mclk),
		.rst_n (rst_n),
		.cap   (abCap)
	);

	capture_reg baReg (
		.mclk  (mclk),
		.rst_n (rst_n),
		.cap   (baCap)
	);

	// ==============================================================
	// Drive selection
	// ==============================================================
	logic              forceIso_q;
	logic              aDrive;
	logic              bDrive;
	logic [LINE_W-1:0] aNext;
	logic [LINE_W-1:0] bNext;

	assign bDrive = bEnS & ~forceIso_q;
	assign aDrive = ~aEnS_n & ~forceIso_q;
	assign bNext  = abSelS ? abCap.value : aSync;
	assign aNext  = baSelS ? baCap.value : bSync;

	// Registered mux output: lines change only at a clock edge,
	// so a select change cannot glitch the bus
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aOut_q <= '0;
			bOut_q <= '0;
			aOe_q  <= 1'b0;
			bOe_q  <= 1'b0;
		end
		else
		begin
			aOut_q <= aNext;
			bOut_q <= bNext;
			aOe_q  <= aDrive;
			bOe_q  <= bDrive;
		end
	end

	assign portALinesOut = aOut_q;
	assign portBLinesOut = bOut_q;
	assign portALinesOe  = aOe_q;
	assign portBLinesOe  = bOe_q;

	// ==============================================================
	// Register bus: write path
	// ==============================================================
	logic              awHave_q;
	logic              wHave_q;
	logic [ADDR_W-1:0] wAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              awTake;
	logic              wTake;
	logic              doWrite;
	logic              awHave_d;
	logic              wHave_d;
	logic              bvalid_d;
	logic              ctrlHit;
	logic              wMapped;
	logic              ctrlWr;

	assign awTake   = awvalid & awready_q;
	assign wTake    = wvalid & wready_q;
	assign doWrite  = awHave_q & wHave_q & ~bvalid_q;
	assign awHave_d = (awHave_q | awTake) & ~doWrite;
	assign wHave_d  = (wHave_q | wTake) & ~doWrite;
	assign bvalid_d = doWrite | (bvalid_q & ~bready);
	assign ctrlHit  = regHit(wAddr_q, CTRL_OFS);
	assign wMapped  = ctrlHit | regHit(wAddr_q, AB_OFS)
		| regHit(wAddr_q, BA_OFS) | regHit(wAddr_q, PINS_OFS)
		| regHit(wAddr_q, LIVE_OFS);
	// Only the low byte of control holds writable bits
	assign ctrlWr   = doWrite & ctrlHit & wStrb_q[0];

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			awHave_q  <= 1'b0;
			wHave_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			awHave_q  <= awHave_d;
			wHave_q   <= wHave_d;
			awready_q <= ~awHave_d & ~bvalid_d;
			wready_q  <= ~wHave_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (doWrite)
				bresp_q <= wMapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (awTake)
			wAddr_q <= awaddr;
		if (wTake)
		begin
			wData_q <= wdata;
			wStrb_q <= wstrb;
		end
	end

	// Control: isolation override and one-cycle capture pulses
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			forceIso_q <= CTRL_ISO_RST;
			swCapAb_q  <= 1'b0;
			swCapBa_q  <= 1'b0;
		end
		else
		begin
			if (ctrlWr)
				forceIso_q <= wData_q[CTRL_ISO_BIT];
			swCapAb_q <= ctrlWr & wData_q[CTRL_CAP_AB_BIT];
			swCapBa_q <= ctrlWr & wData_q[CTRL_CAP_BA_BIT];
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	// ==============================================================
	// Register bus: read path
	// ==============================================================
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        arTake;
	logic        rvalid_d;
	logic [31:0] pinsWord;
	logic [31:0] liveWord;
	logic [31:0] readWord;
	logic        rMapped;

	assign arTake   = arvalid & arready_q;
	assign rvalid_d = arTake | (rvalid_q & ~rready);
	assign pinsWord = ZERO_WORD
		| (32'(bEnS) << PS_BEN) | (32'(aEnS_n) << PS_AEN_N)
		| (32'(abSelS) << PS_ABSEL) | (32'(baSelS) << PS_BASEL)
		| (32'(aOe_q) << PS_ADRIVE) | (32'(bOe_q) << PS_BDRIVE);
	assign liveWord = ZERO_WORD | 32'(aSync)
		| (32'(bSync) << LIVE_B_LSB);
	assign rMapped  = regHit(araddr, CTRL_OFS) | regHit(araddr, AB_OFS)
		| regHit(araddr, BA_OFS) | regHit(araddr, PINS_OFS)
		| regHit(araddr, LIVE_OFS);
	assign readWord =
		regHit(araddr, CTRL_OFS) ? (ZERO_WORD | 32'(forceIso_q)) :
		regHit(araddr, AB_OFS)   ? (ZERO_WORD | 32'(abCap.value)) :
		regHit(araddr, BA_OFS)   ? (ZERO_WORD | 32'(baCap.value)) :
		regHit(araddr, PINS_OFS) ? pinsWord :
		regHit(araddr, LIVE_OFS) ? liveWord : ZERO_WORD;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= ZERO_WORD;
			rresp_q   <= RESP_OKAY;
		end
		else
		begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (arTake)
			begin
				rdata_q <= readWord;
				rresp_q <= rMapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	// ==============================================================
	// Checks
	// ==============================================================
	isolation_hiz_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!bEnS && aEnS_n) |=> (!aOe_q && !bOe_q))
		else $error("port driven while isolated");

	live_a_to_b_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(bEnS && aEnS_n && !abSelS && !forceIso_q)
		|=> (bOe_q && !aOe_q && bOut_q == $past(aSync)))
		else $error("port B not showing live port A");

	stored_a_to_b_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(bEnS && abSelS && !forceIso_q)
		|=> (bOe_q && bOut_q == $past(abCap.value)))
		else $error("port B not showing A-to-B register");

	live_b_to_a_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!bEnS && !aEnS_n && !baSelS && !forceIso_q)
		|=> (aOe_q && !bOe_q && aOut_q == $past(bSync)))
		else $error("port A not showing live port B");

	stored_b_to_a_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!aEnS_n && baSelS && !forceIso_q)
		|=> (aOe_q && aOut_q == $past(baCap.value)))
		else $error("port A not showing B-to-A register");

	both_stored_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(bEnS && !aEnS_n && abSelS && baSelS && !forceIso_q)
		|=> (aOe_q && bOe_q && aOut_q == $past(baCap.value)
			&& bOut_q == $past(abCap.value)))
		else $error("dual stored drive wrong");

	bus_keeper_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(bEnS && !aEnS_n && !abSelS && !baSelS && !forceIso_q)
		|=> (aOut_q == $past(bSync) && bOut_q == $past(aSync)))
		else $error("ports do not reinforce each other");

	store_both_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(bEnS && aEnS_n && baEdge && bOe_q)
		|=> (baCap.value == $past(bOut_q)))
		else $error("B-to-A register missed driven B data");

	write_answer_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		doWrite |=> (bvalid_q && !awready_q && !wready_q))
		else $error("write response not raised");

endmodule

`default_nettype wire

// *** verification/bus_partner.sv ***
// Far-side logic model: resolves both eight-line buses.
// Assumes the bench picks what this side drives; no pulls on data lines.

`timescale 1ns/100ps
`default_nettype none

module bus_partner
	import xcvr_pkg::*;
(
	input  wire logic [LINE_W-1:0] aOut,
	input  wire logic              aOe,
	input  wire logic [LINE_W-1:0] bOut,
	input  wire logic              bOe,
	input  wire logic              mclk,
	input  wire logic [LINE_W-1:0] aDrive,
	input  wire logic              aDriveEn,
	input  wire logic [LINE_W-1:0] bDrive,
	input  wire logic              bDriveEn,
	output logic      [LINE_W-1:0] aWire,
	output logic      [LINE_W-1:0] bWire
);
	// ======
	// Wire resolution
	// Released lines wander so a stale value never looks valid
	logic [LINE_W-1:0] floatPat_q = 8'h5A;

	always @(posedge mclk)
		floatPat_q <= floatPat_q + 8'h3B;

	// Block wins a clash; bench overlaps it for a few cycles after an enable change
	assign aWire = aOe ? aOut : (aDriveEn ? aDrive : floatPat_q);
	assign bWire = bOe ? bOut : (bDriveEn ? bDrive : ~floatPat_q);
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the octal transceiver with register bus.
// Assumes bus_partner resolves both buses; one 20 MHz clock.

`timescale 1ns/100ps
`default_nettype none

module testbench
	import xcvr_pkg::*;
;
	localparam int SETTLE = 8;
	localparam int LIMIT  = 5000;
	logic        mclk, rst_n, bPortDriveEnable, aPortDriveEnable_n;
	logic        aToBCaptureClock, bToACaptureClock, aToBSourceSelect;
	logic        bToASourceSelect, portALinesOe, portBLinesOe, snapReq;
	logic [7:0]  portALinesIn, portALinesOut, portBLinesIn, portBLinesOut;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, aDriveEn, bDriveEn;
	logic [7:0]  awaddr, araddr, aDrive, bDrive, pa, pb, regAB, regBA, eA, eB;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, cfg;
	logic [1:0]  bresp, rresp;
	logic [33:0] expQ[$];
	int          miscompares, checkCount, cyc;

	octal_bus_transceiver_register octal_bus_transceiver_register_inst (
		.mclk, .rst_n, .bPortDriveEnable, .aPortDriveEnable_n,
		.aToBCaptureClock, .bToACaptureClock, .aToBSourceSelect,
		.bToASourceSelect, .portALinesIn, .portALinesOut, .portALinesOe,
		.portBLinesIn, .portBLinesOut, .portBLinesOe, .awvalid, .awready,
		.awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp
	);

	bus_partner bus_partner_inst (
		.mclk, .aOut(portALinesOut), .aOe(portALinesOe),
		.bOut(portBLinesOut), .bOe(portBLinesOe), .aDrive, .aDriveEn,
		.bDrive, .bDriveEn, .aWire(portALinesIn), .bWire(portBLinesIn)
	);

	// ======
	// Clock, timeout and result watcher
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic end_of_test;
		if (expQ.size() != 0)
			miscompares++;
		if (miscompares == 0 && checkCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// An unexpected result pops nothing and compares against its inverse
	task automatic take(input logic [33:0] seen);
		logic [33:0] exp;
		exp = (expQ.size() != 0) ? expQ.pop_front() : ~seen;
		check(seen, exp);
	endtask

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			miscompares++;
			end_of_test();
		end
	end

	always @(posedge mclk)
	begin
		if (bvalid && bready)
			take({32'h0000_0000, bresp});
		if (rvalid && rready)
			take({rresp, rdata});
		if (snapReq)
			take({16'h0000, portALinesOe, portBLinesOe,
				portALinesOe ? portALinesOut : 8'h00,
				portBLinesOe ? portBLinesOut : 8'h00});
	end

	// ======
	// Drivers
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic awDone;
		logic wDone;
		expQ.push_back({32'h0000_0000, r});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awDone = 1'b0;
		wDone = 1'b0;
		while (!(awDone && wDone))
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			awDone = awDone | awready;
			wDone = wDone | wready;
		end
		do @(posedge mclk); while (!bvalid);
		bready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge mclk); while (!rvalid);
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic readRegs;
		axiRead(AB_OFS, {RESP_OKAY, 24'h00_0000, regAB});
		axiRead(BA_OFS, {RESP_OKAY, 24'h00_0000, regBA});
	endtask

	task automatic snap(input logic [33:0] e);
		expQ.push_back(e);
		snapReq <= 1'b1;
		@(posedge mclk);
		snapReq <= 1'b0;
		@(posedge mclk);
	endtask

	// Far side drives a port only while the block leaves it free
	task automatic setPins(input logic [3:0] c);
		{bPortDriveEnable, aPortDriveEnable_n} <= c[3:2];
		{aToBSourceSelect, bToASourceSelect} <= c[1:0];
		pa = 8'($urandom);
		pb = 8'($urandom);
		aDrive <= pa;
		bDrive <= pb;
		aDriveEn <= c[2];
		bDriveEn <= !c[3];
		repeat (SETTLE) @(posedge mclk);
	endtask

	// High for three cycles, then low for SETTLE cycles, so the synchroniser sees the edge
	task automatic pulse(input logic ab, input logic ba);
		aToBCaptureClock <= ab;
		bToACaptureClock <= ba;
		repeat (3) @(posedge mclk);
		aToBCaptureClock <= 1'b0;
		bToACaptureClock <= 1'b0;
		repeat (SETTLE) @(posedge mclk);
	endtask

	// ======
	// Scenarios
	initial
	begin
		rst_n = 1'b0;
		{bPortDriveEnable, aToBCaptureClock, bToACaptureClock} = 3'h0;
		{aToBSourceSelect, bToASourceSelect, snapReq} = 3'h0;
		aPortDriveEnable_n = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{aDriveEn, bDriveEn} = 2'h0;
		{awaddr, araddr, aDrive, bDrive} = 32'h0000_0000;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		void'($urandom(32'hc809_baec));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		snap(34'h0_0000_0000);
		setPins(4'b0111);
		pulse(1'b1, 1'b1);
		regAB = pa;
		regBA = pb;
		readRegs();
		setPins(4'b0111);
		readRegs();
		setPins(4'b1100);
		pulse(1'b1, 1'b1);
		regAB = pa;
		regBA = pa;
		readRegs();
		setPins(4'b0000);
		pulse(1'b1, 1'b1);
		regAB = pb;
		regBA = pb;
		readRegs();
		setPins(4'b1110);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		regAB = pa;
		regBA = pa;
		readRegs();
		setPins(4'b0111);
		pulse(1'b1, 1'b1);
		regAB = pa;
		regBA = pb;
		readRegs();
		for (int c = 0; c < 16; c++)
		begin
			cfg = 4'(c);
			if (cfg[3] && !cfg[2] && cfg[1:0] != 2'b11)
				continue;
			setPins(cfg);
			eA = !cfg[2] ? (cfg[0] ? regBA : pb) : 8'h00;
			eB = cfg[3] ? (cfg[1] ? regAB : pa) : 8'h00;
			snap({16'h0000, !cfg[2], cfg[3], eA, eB});
			axiRead(PINS_OFS, {RESP_OKAY, 26'h000_0000, cfg[3], !cfg[2],
				cfg[0], cfg[1], cfg[2], cfg[3]});
		end
		setPins(4'b1100);
		{bPortDriveEnable, aPortDriveEnable_n} <= 2'b10;
		repeat (SETTLE) @(posedge mclk);
		aDriveEn <= 1'b0;
		repeat (SETTLE) @(posedge mclk);
		axiRead(LIVE_OFS, {RESP_OKAY, 16'h0000, pa, pa});
		axiWrite(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
		repeat (SETTLE) @(posedge mclk);
		snap(34'h0_0000_0000);
		axiRead(CTRL_OFS, {RESP_OKAY, 32'h0000_0001});
		axiWrite(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		setPins(4'b0100);
		axiWrite(CTRL_OFS, 32'h0000_0006, RESP_OKAY);
		repeat (SETTLE) @(posedge mclk);
		regAB = pa;
		regBA = pb;
		axiRead(CTRL_OFS, {RESP_OKAY, 32'h0000_0000});
		axiWrite(AB_OFS, 32'(~regAB), RESP_OKAY);
		readRegs();
		wstrb <= 4'hE;
		axiWrite(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
		wstrb <= 4'hF;
		axiRead(CTRL_OFS, {RESP_OKAY, 32'h0000_0000});
		axiWrite(8'h14, 32'h0000_0001, RESP_SLVERR);
		axiRead(8'h14, {RESP_SLVERR, 32'h0000_0000});
		end_of_test();
	end
endmodule

`default_nettype wire
